// ===== design/plp_link.sv
// Powerline link framer: channel access, framing, retries, rx filter
// Assumes modem byte stream on clk, carrier level from an async front end
//
// What this block does
// RULE1 - Listen one of seven random periods 85..115 ms; line must stay idle
// RULE2 - Band busy only after carrier above threshold lasts 4 ms
// RULE3 - Busy band restarts listening with a fresh random period
// RULE4 - Access timeout abandons the send, flags failure
// RULE5 - Each packet is preceded by one preamble byte 0xAB
// RULE6 - Header 6..20 bytes, payload 0..31 bytes, one trailing CRC byte
// RULE7 - Source kind bit: 0 logical, 1 physical
// RULE8 - Destination kind: 00 logical, 01 group, 10 physical, 11 invalid
// RULE9 - Service bit: 0 unacknowledged, 1 acknowledged
// RULE10 - Response bit set only on ack or response packets
// RULE11 - Reserved header bits are sent as zero
// RULE12 - Header carries a 4-bit CRC; bad header aborts reception
// RULE13 - Last byte is 8-bit CRC over header and payload
// RULE14 - Sequence number advances for each new packet
// RULE15 - Ack mode resends unanswered packet, same number, while retries remain
// RULE16 - Unack mode sends retry count plus one copies
// RULE17 - Duplicate from same source, number and CRC is not reported
// RULE18 - Duplicate is still acked in ack service
// RULE19 - Node holds 8 or 16 bit logical and 64-bit physical address
// RULE20 - Single-group mode: membership of one of 256 groups
// RULE21 - Multiple-group mode: any subset of eight groups, plus one single
// RULE22 - Group 0x00 is broadcast, accepted by every node
// RULE23 - Group addressing forces unacknowledged service
// RULE24 - Host reads and writes payloads over the register port
// RULE25 - Drop received packets with invalid kind or bad length silently
// RULE26 - Header size follows address kinds: 1, 2 or 8 bytes each
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "plp_defines.svh"
module plp_link #(
   parameter int unsigned MS_CYC   = `PLP_MS_US * `PLP_CLK_MHZ,
   parameter int unsigned BUSY_CYC = `PLP_BUSY_US * `PLP_CLK_MHZ,
   // Arbitrary value
   parameter logic [63:0] OWN_PHY  = 64'h0123_4567_89AB_CDEF
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // Carrier level, asynchronous
   input  wire logic [7:0] carrier_lvl,
   // Modem transmit bytes
   output logic      [7:0] tx_data,
   output logic            tx_valid,
   input  wire logic       tx_ready,
   // Modem receive bytes
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_valid,
   // Status
   output logic            band_busy
);
   import plp_pkg::*;

   // ================
   // State
   typedef struct packed {
      logic [7:0]  cs1;
      logic [7:0]  cs2;
      logic [31:0] bcnt;
      logic        busy;
      logic [31:0] mcnt;
      logic        tick;
      logic [15:0] lfsr;
      logic [7:0]  rdat;
      logic        go;
      logic [6:0]  ctl;
      logic [3:0]  retry;
      logic [7:0]  thr;
      logic [7:0]  cmd;
      logic [4:0]  len;
      logic [15:0] lad;
      logic [7:0]  grp;
      logic [7:0]  gmask;
      logic [63:0] dst;
      plp_buf_t    tbuf;
      logic [5:0]  stat;
      plp_tx_st_t  ts;
      logic [6:0]  lcnt;
      logic [6:0]  ltgt;
      logic [10:0] tcnt;
      logic [9:0]  acnt;
      logic [3:0]  tries;
      logic [3:0]  seq;
      logic        cack;
      logic [7:0]  cflg;
      logic [7:0]  ccmd;
      logic [4:0]  clen;
      logic [3:0]  cseq;
      logic [3:0]  cdl;
      logic [3:0]  csl;
      logic [63:0] cdst;
      logic [63:0] csrc;
      logic [63:0] dsh;
      logic [63:0] ssh;
      logic [5:0]  tix;
      logic [3:0]  hcrc;
      logic [7:0]  pcrc;
      logic [7:0]  txd;
      logic        txv;
      logic        ap;
      logic [1:0]  adk;
      logic [63:0] asrc;
      logic [3:0]  aseq;
      logic [7:0]  acmd;
      plp_rx_st_t  rs;
      logic [4:0]  rix;
      logic [4:0]  pix;
      logic [7:0]  rflg;
      logic [7:0]  rcmd;
      logic [4:0]  rlen;
      logic [3:0]  rseq;
      logic [3:0]  rdl;
      logic [3:0]  rsl;
      logic [63:0] rdst;
      logic [63:0] rsrc;
      logic [3:0]  rhc;
      logic [7:0]  rpc;
      plp_buf_t    rtmp;
      plp_buf_t    rbuf;
      logic [4:0]  olen;
      logic [7:0]  ocmd;
      logic        lv;
      logic [63:0] lsrc;
      logic [3:0]  lseq;
      logic [7:0]  lpc;
   } plp_st_t;

   plp_st_t     s;
   plp_st_t     n;
   logic        act;
   logic        ext;
   logic        sk;
   logic [1:0]  dk;
   logic [2:0]  lidx;
   logic [6:0]  pick;
   logic [63:0] osrc;
   logic [5:0]  hl;
   logic [5:0]  last;
   logic [5:0]  pi;
   logic [7:0]  tb;
   logic        sd;
   logic        ss;
   logic [4:0]  re;
   logic [7:0]  g;
   logic        match;
   logic        dup;
   logic        ackhit;

   // ================
   // Helpers
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return r;
   endfunction : crc8

   function automatic logic [3:0] crc4(input logic [3:0] c, input logic [7:0] d);
      logic [3:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[2:0], 1'b0} ^ ((r[3] ^ d[i]) ? 4'h3 : 4'h0);
      end
      return r;
   endfunction : crc4

   // Address field size in bytes
   function automatic logic [3:0] alen(input logic [1:0] k, input logic e);
      return (k == `PLP_DK_PHY) ? 4'h8 : ((k == `PLP_DK_LOG && e) ? 4'h2 : 4'h1); // RULE26
   endfunction : alen

   // ================
   // Next state
   always_comb begin
      n = s;
      n.rdat = 8'h00;
      n.tick = 1'b0;
      act = (s.ts != T_IDLE);
      ext = s.ctl[`PLP_C_EXT];
      sk = s.ctl[`PLP_C_SK];
      dk = s.ctl[5:4];
      lidx = (s.lfsr[2:0] == 3'h7) ? 3'h3 : s.lfsr[2:0];
      pick = 7'(`PLP_LSN_MS + `PLP_STEP_MS * lidx); // RULE1
      osrc = sk ? OWN_PHY : (ext ? {s.lad, 48'h0} : {s.lad[7:0], 56'h0}); // RULE19
      hl = {2'h0, s.cdl} + {2'h0, s.csl} + 6'h4; // RULE6
      last = hl + {1'b0, s.clen} + 6'h1;
      pi = s.tix - hl - 6'h1;
      re = {1'b0, s.rdl} + {1'b0, s.rsl};
      g = s.rdst[63:56];
      ackhit = 1'b0;
      dup = 1'b0;

      // Carrier persistence
      n.cs1 = carrier_lvl;
      n.cs2 = s.cs1;
      if (s.cs2 > s.thr) begin
         if (s.bcnt >= BUSY_CYC - 1) begin
            n.busy = 1'b1; // RULE2
         end else begin
            n.bcnt = s.bcnt + 32'h1;
         end
      end else begin
         n.bcnt = 32'h0;
         n.busy = 1'b0;
      end
      if (s.mcnt == MS_CYC - 1) begin
         n.mcnt = 32'h0;
         n.tick = 1'b1;
      end else begin
         n.mcnt = s.mcnt + 32'h1;
      end
      n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

      // Register writes
      if (wr) begin
         case (addr)
            `PLP_A_CTRL: begin
               n.ctl = wdata[6:0];
               n.go = s.go | wdata[0];
            end
            `PLP_A_RETRY: n.retry = wdata[3:0];
            `PLP_A_THR: n.thr = wdata;
            `PLP_A_CMD: n.cmd = wdata;
            `PLP_A_LEN: n.len = wdata[4:0];
            `PLP_A_LADLO: n.lad[7:0] = wdata;
            `PLP_A_LADHI: n.lad[15:8] = wdata;
            `PLP_A_GRP: n.grp = wdata;
            `PLP_A_GMASK: n.gmask = wdata;
            `PLP_A_STAT: n.stat = s.stat & ~wdata[5:0];
            default: begin
               if (addr[7:3] == `PLP_A_DST) begin
                  n.dst[8 * (7 - addr[2:0]) +: 8] = wdata;
               end
               if (addr[7:5] == `PLP_A_TXB && addr[4:0] != 5'h1F) begin
                  n.tbuf[addr[4:0]] = wdata; // RULE24
               end
            end
         endcase
      end

      // Register reads
      if (rd) begin
         case (addr)
            `PLP_A_CTRL: n.rdat = {1'b0, s.ctl[6:1], act};
            `PLP_A_RETRY: n.rdat = {4'h0, s.retry};
            `PLP_A_THR: n.rdat = s.thr;
            `PLP_A_CMD: n.rdat = s.cmd;
            `PLP_A_LEN: n.rdat = {3'h0, s.len};
            `PLP_A_LADLO: n.rdat = s.lad[7:0];
            `PLP_A_LADHI: n.rdat = s.lad[15:8];
            `PLP_A_GRP: n.rdat = s.grp;
            `PLP_A_GMASK: n.rdat = s.gmask;
            `PLP_A_STAT: n.rdat = {2'h0, s.stat[5], s.busy, s.stat[3:1], act};
            `PLP_A_RXLEN: n.rdat = {3'h0, s.olen};
            `PLP_A_RXCMD: n.rdat = s.ocmd;
            `PLP_A_SEQ: n.rdat = {4'h0, s.seq};
            default: begin
               if (addr[7:3] == `PLP_A_DST) begin
                  n.rdat = s.dst[8 * (7 - addr[2:0]) +: 8];
               end
               if (addr[7:3] == `PLP_A_PHY) begin
                  n.rdat = OWN_PHY[8 * (7 - addr[2:0]) +: 8];
               end
               if (addr[7:5] == `PLP_A_TXB && addr[4:0] != 5'h1F) begin
                  n.rdat = s.tbuf[addr[4:0]];
               end
               if (addr[7:5] == `PLP_A_RXB && addr[4:0] != 5'h1F) begin
                  n.rdat = s.rbuf[addr[4:0]]; // RULE24
               end
            end
         endcase
      end

      // Address filter
      case (s.rflg[6:5])
         `PLP_DK_LOG: match = ext ? (s.rdst[63:48] == s.lad) : (g == s.lad[7:0]);
         `PLP_DK_GRP: match = (g == 8'h00) || (g == s.grp) || // RULE22 RULE20
                              (g[7:3] == 5'h00 && s.gmask[g[2:0]]); // RULE21
         `PLP_DK_PHY: match = (s.rdst == OWN_PHY);
         default: match = 1'b0;
      endcase

      // Receive
      if (rx_valid) begin
         unique case (s.rs)
            R_HUNT: begin
               if (rx_data == `PLP_PRE) begin
                  n.rs = R_HDR;
                  n.rix = 5'h0;
                  n.pix = 5'h0;
                  n.rhc = 4'h0;
                  n.rpc = 8'h00;
                  n.rdst = 64'h0;
                  n.rsrc = 64'h0;
               end
            end
            R_HDR: begin
               n.rix = s.rix + 5'h1;
               n.rhc = crc4(s.rhc, rx_data);
               n.rpc = crc8(s.rpc, rx_data);
               if (s.rix == 5'h0) begin
                  n.rflg = rx_data;
                  n.rdl = alen(rx_data[6:5], ext);
                  n.rsl = alen({rx_data[7], 1'b0}, ext);
                  if (rx_data[6:5] == `PLP_DK_BAD) begin
                     n.rs = R_HUNT; // RULE25 RULE8
                  end
               end else if (s.rix <= {1'b0, s.rdl}) begin
                  n.rdst[8 * (8 - s.rix) +: 8] = rx_data;
               end else if (s.rix <= re) begin
                  n.rsrc[8 * (8 + s.rdl - s.rix) +: 8] = rx_data;
               end else if (s.rix == re + 5'h1) begin
                  n.rcmd = rx_data;
               end else if (s.rix == re + 5'h2) begin
                  n.rlen = rx_data[4:0];
                  if (rx_data[7:5] != 3'h0) begin
                     n.rs = R_HUNT; // RULE25
                  end
               end else begin
                  n.rseq = rx_data[7:4];
                  if (crc4(s.rhc, {rx_data[7:4], 4'h0}) != rx_data[3:0]) begin
                     n.rs = R_HUNT; // RULE12
                  end else begin
                     n.rs = (s.rlen == 5'h0) ? R_CRC : R_PAY;
                  end
               end
            end
            R_PAY: begin
               n.rtmp[s.pix] = rx_data;
               n.rpc = crc8(s.rpc, rx_data);
               n.pix = s.pix + 5'h1;
               if (s.pix == s.rlen - 5'h1) begin
                  n.rs = R_CRC;
               end
            end
            R_CRC: begin
               n.rs = R_HUNT;
               if (rx_data == s.rpc && match) begin // RULE13
                  if (s.rflg[1]) begin
                     ackhit = (s.ts == T_ACKW) && (s.rseq == s.cseq);
                  end else begin
                     dup = s.lv && s.lsrc == s.rsrc && s.lseq == s.rseq && s.lpc == rx_data;
                     if (!dup) begin // RULE17
                        n.rbuf = s.rtmp;
                        n.olen = s.rlen;
                        n.ocmd = s.rcmd;
                        n.stat[`PLP_S_RXRDY] = 1'b1;
                        n.lv = 1'b1;
                        n.lsrc = s.rsrc;
                        n.lseq = s.rseq;
                        n.lpc = rx_data;
                     end
                     if (s.rflg[4] && s.rflg[6:5] != `PLP_DK_GRP) begin // RULE18
                        n.ap = 1'b1;
                        n.adk = {s.rflg[7], 1'b0};
                        n.asrc = s.rsrc;
                        n.aseq = s.rseq;
                        n.acmd = s.rcmd;
                     end
                  end
               end
            end
         endcase
      end

      // Transmit byte selection
      sd = 1'b0;
      ss = 1'b0;
      if (s.tix == 6'h0) begin
         tb = `PLP_PRE; // RULE5
      end else if (s.tix == 6'h1) begin
         tb = s.cflg;
      end else if (s.tix <= {2'h0, s.cdl} + 6'h1) begin
         tb = s.dsh[63:56];
         sd = 1'b1;
      end else if (s.tix < hl - 6'h2) begin
         tb = s.ssh[63:56];
         ss = 1'b1;
      end else if (s.tix == hl - 6'h2) begin
         tb = s.ccmd;
      end else if (s.tix == hl - 6'h1) begin
         tb = {3'h0, s.clen}; // RULE11
      end else if (s.tix == hl) begin
         tb = {s.cseq, crc4(s.hcrc, {s.cseq, 4'h0})}; // RULE12
      end else if (s.tix < last) begin
         tb = s.tbuf[pi[4:0]];
      end else begin
         tb = s.pcrc; // RULE13
      end

      // Transmit sequencer
      unique case (s.ts)
         T_IDLE: begin
            if (s.ap) begin
               n.ap = 1'b0;
               n.cack = 1'b1;
               n.cflg = {sk, s.adk, 1'b0, 2'h0, 1'b1, 1'b0}; // RULE10
               n.cdst = s.asrc;
               n.cdl = alen(s.adk, ext);
               n.ccmd = s.acmd;
               n.clen = 5'h0;
               n.cseq = s.aseq;
               n.tries = 4'h0;
            end else if (s.go) begin
               n.go = 1'b0;
               n.cack = 1'b0;
               n.seq = s.seq + 4'(dk != `PLP_DK_BAD); // RULE14
               n.cseq = s.seq + 4'h1;
               n.cflg = {sk, dk, s.ctl[`PLP_C_SVC] && dk != `PLP_DK_GRP, // RULE23 RULE9 RULE7
                         2'h0, s.ctl[`PLP_C_RSP], 1'b0}; // RULE11
               n.cdst = s.dst;
               n.cdl = alen(dk, ext);
               n.ccmd = s.cmd;
               n.clen = s.len;
               n.tries = s.retry;
            end
            if (s.ap || (s.go && dk != `PLP_DK_BAD)) begin
               n.csrc = osrc;
               n.csl = alen({sk, 1'b0}, ext);
               n.ts = T_LISTEN;
               n.lcnt = 7'h0;
               n.ltgt = pick;
               n.tcnt = 11'h0;
            end else if (s.go) begin
               n.stat[`PLP_S_FAIL] = 1'b1; // RULE8
            end
         end
         T_LISTEN: begin
            if (s.tick) begin
               n.lcnt = s.lcnt + 7'h1;
               n.tcnt = s.tcnt + 11'h1;
            end
            if (s.busy) begin
               n.lcnt = 7'h0; // RULE3
               n.ltgt = pick;
            end
            if (s.tcnt >= 11'(`PLP_TOUT_MS)) begin
               n.stat[`PLP_S_FAIL] = 1'b1; // RULE4
               n.ts = T_IDLE;
            end else if (!s.busy && s.lcnt >= s.ltgt) begin // RULE1
               n.ts = T_SEND;
               n.tix = 6'h0;
               n.txv = 1'b0;
               n.dsh = s.cdst;
               n.ssh = s.csrc;
               n.hcrc = 4'h0;
               n.pcrc = 8'h00;
            end
         end
         T_SEND: begin
            if (!s.txv || tx_ready) begin
               if (s.tix == last + 6'h1) begin
                  n.txv = 1'b0;
                  if (s.cack) begin
                     n.ts = T_IDLE;
                  end else if (s.cflg[4]) begin
                     n.ts = T_ACKW;
                     n.acnt = 10'h0;
                  end else if (s.tries != 4'h0) begin
                     n.tries = s.tries - 4'h1; // RULE16
                     n.ts = T_LISTEN;
                     n.lcnt = 7'h0;
                     n.ltgt = pick;
                     n.tcnt = 11'h0;
                  end else begin
                     n.stat[`PLP_S_DONE] = 1'b1;
                     n.ts = T_IDLE;
                  end
               end else begin
                  n.txv = 1'b1;
                  n.txd = tb;
                  n.tix = s.tix + 6'h1;
                  if (sd) n.dsh = {s.dsh[55:0], 8'h00};
                  if (ss) n.ssh = {s.ssh[55:0], 8'h00};
                  if (s.tix != 6'h0 && s.tix < hl) n.hcrc = crc4(s.hcrc, tb);
                  if (s.tix != 6'h0 && s.tix < last) n.pcrc = crc8(s.pcrc, tb);
               end
            end
         end
         T_ACKW: begin
            if (s.tick) begin
               n.acnt = s.acnt + 10'h1;
            end
            if (ackhit) begin
               n.stat[`PLP_S_DONE] = 1'b1;
               n.ts = T_IDLE;
            end else if (s.acnt >= 10'(`PLP_ACK_MS)) begin
               if (s.tries != 4'h0) begin
                  n.tries = s.tries - 4'h1; // RULE15
                  n.ts = T_LISTEN;
                  n.lcnt = 7'h0;
                  n.ltgt = pick;
                  n.tcnt = 11'h0;
               end else begin
                  n.stat[`PLP_S_NOACK] = 1'b1;
                  n.ts = T_IDLE;
               end
            end
         end
      endcase
   end

   // ================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.lfsr <= `PLP_LFSR_RST;
         s.thr <= `PLP_THR_RST;
      end else begin
         s <= n;
      end
   end

   assign rdata = s.rdat;
   assign tx_data = s.txd;
   assign tx_valid = s.txv;
   assign band_busy = s.busy;
endmodule : plp_link

// ===== design/plp_defines.svh
// Link framer constants
// Assumes a 200 MHz clock
`ifndef PLP_DEFINES_SVH
`define PLP_DEFINES_SVH
`define PLP_PRE       8'hAB
`define PLP_CLK_MHZ   200
`define PLP_MS_US     1000
`define PLP_BUSY_US   4000
`define PLP_LSN_MS    85
`define PLP_STEP_MS   5
`define PLP_TOUT_MS   1100
`define PLP_ACK_MS    500
`define PLP_THR_RST   8'h80
`define PLP_LFSR_RST  16'hACE1
`define PLP_A_CTRL    8'h00
`define PLP_A_RETRY   8'h01
`define PLP_A_THR     8'h02
`define PLP_A_CMD     8'h03
`define PLP_A_LEN     8'h04
`define PLP_A_LADLO   8'h05
`define PLP_A_LADHI   8'h06
`define PLP_A_GRP     8'h07
`define PLP_A_GMASK   8'h08
`define PLP_A_STAT    8'h09
`define PLP_A_RXLEN   8'h0A
`define PLP_A_RXCMD   8'h0B
`define PLP_A_SEQ     8'h0C
`define PLP_A_DST     5'h02
`define PLP_A_PHY     5'h03
`define PLP_A_TXB     3'h1
`define PLP_A_RXB     3'h2
`define PLP_C_SVC     1
`define PLP_C_EXT     2
`define PLP_C_SK      3
`define PLP_C_RSP     6
`define PLP_S_DONE    1
`define PLP_S_FAIL    2
`define PLP_S_RXRDY   3
`define PLP_S_NOACK   5
`define PLP_DK_LOG    2'h0
`define PLP_DK_GRP    2'h1
`define PLP_DK_PHY    2'h2
`define PLP_DK_BAD    2'h3
`endif

// ===== design/plp_pkg.sv
// Types of the link framer
// Assumes nothing beyond the defines header
package plp_pkg;
   typedef enum logic [1:0] {
      T_IDLE   = 2'b00,
      T_LISTEN = 2'b01,
      T_SEND   = 2'b10,
      T_ACKW   = 2'b11
   } plp_tx_st_t;
   typedef enum logic [1:0] {
      R_HUNT = 2'b00,
      R_HDR  = 2'b01,
      R_PAY  = 2'b10,
      R_CRC  = 2'b11
   } plp_rx_st_t;
   typedef logic [30:0][7:0] plp_buf_t;
endpackage : plp_pkg

// ===== dv/plp_link_asserts.sv
// Port checker of the link framer
// Assumes bind into plp_link
`timescale 1ns/1ps
`include "plp_defines.svh"
module plp_link_asserts #(
   parameter int unsigned MS_CYC   = 20,
   parameter int unsigned BUSY_CYC = 40
) (
   // Top module ports
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic [7:0] carrier_lvl,
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       band_busy
);
   logic [7:0]  thr_ff;
   logic [31:0] hi_ff;
   logic [31:0] idle_ff;
   logic [5:0]  idx_ff;
   // ================
   // Run lengths, byte index
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         thr_ff  <= `PLP_THR_RST;
         hi_ff   <= '0;
         idle_ff <= '0;
         idx_ff  <= '0;
      end else begin
         if (wr && addr == `PLP_A_THR) thr_ff <= wdata;
         hi_ff   <= (carrier_lvl > thr_ff) ? hi_ff + 1 : '0;
         idle_ff <= band_busy ? '0 : idle_ff + 1;
         idx_ff  <= !tx_valid ? '0 : idx_ff + 6'(tx_ready);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   sequence s_flags;
      tx_valid && idx_ff == 6'd1;
   endsequence
   chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata not zero");
   chk_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
      else $error("tx byte not held");
   chk_busy_late: assert property ($rose(band_busy) |-> hi_ff >= BUSY_CYC)
      else $error("busy too early");
   chk_busy_rise: assert property (hi_ff == BUSY_CYC + 6 |-> band_busy)
      else $error("busy missing");
   chk_preamble_first: assert property ($rose(tx_valid) |-> tx_data == `PLP_PRE)
      else $error("no preamble");
   chk_listen_idle: assert property ($rose(tx_valid) |-> idle_ff >= 84 * MS_CYC)
      else $error("listen too short");
   chk_flags_unused_bit: assert property (s_flags |-> tx_data[3:2] == 2'b00 && !tx_data[0] && tx_data[6:5] != 2'b11)
      else $error("bad flags byte");
   chk_group_unack: assert property (s_flags and tx_data[6:5] == 2'b01 |-> !tx_data[4])
      else $error("group sent acked");
endmodule : plp_link_asserts

bind plp_link plp_link_asserts #(.MS_CYC(MS_CYC), .BUSY_CYC(BUSY_CYC)) u_chk (.clk, .rst, .addr, .wdata, .wr,
   .rd, .rdata, .carrier_lvl, .tx_data, .tx_valid, .tx_ready, .band_busy);

// ===== dv/plp_modem_model.sv
// Modem model: takes tx bytes with stalls, sends rx bytes
// Assumes the framer clock
`timescale 1ns/1ps
module plp_modem_model (
   // Clock
   input wire logic       clk,
   // Framer transmit side
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   output logic           tx_ready,
   // Framer receive side
   output logic     [7:0] rx_data,
   output logic           rx_valid
);
   logic [7:0] got[$];
   int         n = 0;
   initial {tx_ready, rx_data, rx_valid} = 10'h000;
   // Stall one cycle in three
   always @(posedge clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      n <= n + 1;
      tx_ready <= (n % 3 != 0);
   end
   // Idle line shows the inverse of the last byte
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge clk);
         rx_data  <= b[i];
         rx_valid <= 1'b1;
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_data  <= ~b[i];
      end
   endtask : send
endmodule : plp_modem_model

// ===== dv/test_plp_link.sv
// Self-checking bench of the link framer
// Assumes a short ms tick and the modem model on the far side
`timescale 1ns/1ps
`include "plp_defines.svh"
module test_plp_link;
   import plp_pkg::*;
   localparam int unsigned MS  = 20;
   // Arbitrary value
   localparam logic [63:0] PHY = 64'h1122_3344_5566_7788;
   logic       clk, rst, wr, rd, tx_valid, tx_ready, rx_valid, band_busy;
   logic [7:0] addr, wdata, rdata, carrier_lvl, tx_data, rx_data;
   logic [7:0] p[$];
   int         fails = 0;
   int         total_checks = 0;
   plp_link #(.MS_CYC(MS), .BUSY_CYC(40), .OWN_PHY(PHY)) DUT (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .carrier_lvl, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .band_busy);
   plp_modem_model M (.clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ================
   // Tasks
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic check(input logic [7:0] g, e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
      end
   endtask : check
   task automatic rchk(input logic [7:0] a, e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, e);
   endtask : rchk
   function automatic logic [7:0] crc(input logic [7:0] b[$], input int w, input logic [7:0] poly);
      logic [7:0] c = 8'h00;
      foreach (b[i])
         for (int k = 7; k >= 0; k--) c = ((c << 1) ^ ((c[w-1] ^ b[i][k]) ? poly : 8'h00)) & 8'((1 << w) - 1);
      return c;
   endfunction : crc
   task automatic mk(input logic [7:0] f, d, sa, input logic [3:0] n, input logic h, input logic [7:0] pl[$]);
      logic [7:0] c;
      p = '{f, d, sa, 8'h09, 8'(pl.size())};
      p.push_back({n, 4'h0});
      c = crc(p, 4, 8'h03);
      p[5] = {n, c[3:0] ^ {3'b000, h}};
      p = {p, pl};
      p.push_back(crc(p, 8, 8'h07));
      p.push_front(`PLP_PRE);
   endtask : mk
   task automatic rx(input logic [7:0] f, d, input logic [3:0] n, input logic h, input logic [7:0] e);
      mk(f, d, 8'h22, n, h, '{8'h77});
      M.send(p);
      repeat (4) @(posedge clk);
      rchk(`PLP_A_STAT, e);
      wr_reg(`PLP_A_STAT, 8'h2E);
   endtask : rx
   task automatic wait_got(input int n);
      for (int i = 0; i < 6000 && M.got.size() < n; i++)
         @(posedge clk);
   endtask : wait_got
   task automatic results;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      repeat (50000) @(posedge clk);
      fails++;
      results();
   end
   // ================
   // Tests
   initial begin
      {rst, wr, rd, addr, wdata, carrier_lvl} = {3'b100, 24'h00_0000};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rchk(`PLP_A_THR, `PLP_THR_RST);
      wr_reg(8'h70, 8'h55);
      rchk(8'h70, 8'h00);
      wr_reg(8'h21, 8'h3C);
      wr_reg(8'h20, 8'hC3);
      rchk(8'h21, 8'h3C);
      rchk(8'h18, PHY[63:56]);
      wr_reg(`PLP_A_LADLO, 8'h11);
      wr_reg(8'h10, 8'h5A);
      wr_reg(`PLP_A_CMD, 8'h09);
      wr_reg(`PLP_A_LEN, 8'h02);
      wr_reg(`PLP_A_RETRY, 8'h01);
      $display("registers done");
      carrier_lvl <= 8'h80;
      repeat (60) @(posedge clk);
      check({7'h00, band_busy}, 8'h00);
      carrier_lvl <= 8'h81;
      repeat (30) @(posedge clk);
      check({7'h00, band_busy}, 8'h00);
      repeat (20) @(posedge clk);
      rchk(`PLP_A_STAT, 8'h10);
      carrier_lvl <= 8'h00;
      $display("band busy done");
      wr_reg(`PLP_A_CTRL, 8'h01);
      wait_got(20);
      mk(8'h00, 8'h5A, 8'h11, 4'h1, 1'b0, '{8'hC3, 8'h3C});
      for (int i = 0; i < 20; i++)
         check(M.got[i], p[i % 10]);
      repeat (5) @(posedge clk);
      rchk(`PLP_A_STAT, 8'h02);
      wr_reg(`PLP_A_RETRY, 8'h00);
      wr_reg(`PLP_A_CTRL, 8'h13);
      wait_got(30);
      mk(8'h20, 8'h5A, 8'h11, 4'h2, 1'b0, '{8'hC3, 8'h3C});
      for (int i = 0; i < 10; i++)
         check(M.got[20 + i], p[i]);
      $display("transmit done");
      wr_reg(`PLP_A_STAT, 8'h2E);
      carrier_lvl <= 8'hFF;
      repeat (60) @(posedge clk);
      wr_reg(`PLP_A_CTRL, 8'h01);
      repeat (1100 * MS + 400) @(posedge clk);
      rchk(`PLP_A_STAT, 8'h14);
      check(8'(M.got.size()), 8'd30);
      carrier_lvl <= 8'h00;
      wr_reg(`PLP_A_STAT, 8'h2E);
      wr_reg(`PLP_A_CTRL, 8'h31);
      repeat (3) @(posedge clk);
      rchk(`PLP_A_STAT, 8'h04);
      wr_reg(`PLP_A_STAT, 8'h2E);
      $display("access failure done");
      rx(8'h00, 8'h11, 4'h3, 1'b0, 8'h08);
      rchk(`PLP_A_RXLEN, 8'h01);
      rchk(`PLP_A_RXCMD, 8'h09);
      rchk(8'h40, 8'h77);
      rx(8'h00, 8'h11, 4'h3, 1'b0, 8'h00);
      rx(8'h00, 8'h11, 4'h4, 1'b1, 8'h00);
      rx(8'h60, 8'h11, 4'h5, 1'b0, 8'h00);
      rx(8'h20, 8'h00, 4'h6, 1'b0, 8'h08);
      $display("receive done");
      results();
   end
endmodule : test_plp_link
